// ==== core/cwm_calibration_word_map.v.sv ====
// calibration word map: latches the stored word, checks it, serves fields on a register port
// assumes the stored word is stable in the idle cycle after reset or a load request, when it is latched, and comes from the same clock domain
// Notes on behaviour
// RULE1 - four gain/current words at bits 162..119
// RULE2 - gain-100 current word must be zero
// RULE3 - gain-24 factor at bits 118..108
// RULE4 - gain-1 at 85..75, gain-100 at 74..64
// RULE5 - temperature slope factor at bits 63..53
// RULE6 - 8-bit checksum in low bits 51..44
// RULE7 - checksum equals sum of non-checksum bits
// RULE8 - 6-bit clock trim, upper three read ones
// RULE9 - oscillator kHz equals 240 plus trim
// RULE10 - reading at 23 C at bits 34..24
// RULE11 - serial number bytes at 23..0
// RULE12 - calibration procedure writes gain fields externally
// RULE13 - subfields msb-first, contiguous descending bits
// RULE14 - flag checksum mismatch and nonzero gain-100 word
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module cwm_calibration_word_map
  import cwm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // stored word from the nonvolatile array, written by calibration
  input wire logic [CWM_WORD_W-1:0] stored_word_i, // see RULE12
  // register port
  input wire cwm_bus_req_t bus_i,
  output logic [CWM_DATA_W-1:0] rdata_o,
  // decoded trims and status
  output cwm_trim_t trim_group_o,
  output logic [CWM_CLK_W-1:0] clock_trim_number_o,
  output logic csum_err_o,
  output logic por_err_o,
  output logic word_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // field helpers

  function automatic logic [CWM_CAL_W-1:0] cal_at(input logic [CWM_WORD_W-1:0] w, input int unsigned lsb);
    cal_at = w[lsb +: CWM_CAL_W]; // see RULE13
  endfunction : cal_at

  function automatic logic [CWM_DATA_W-1:0] pad(input logic [CWM_CAL_W-1:0] v);
    pad = {{(CWM_DATA_W-CWM_CAL_W){1'b0}}, v};
  endfunction : pad

  // sum of every bit outside the checksum field, kept to 8 bits
  function automatic logic [CWM_CSUM_W-1:0] bit_sum(input logic [CWM_WORD_W-1:0] w);
    logic [CWM_CSUM_W-1:0] s;
    s = '0;
    for (int unsigned i = 0; i < CWM_WORD_W; i++) begin
      if (i < CWM_CSUM_LSB || i >= CWM_CSUM_LSB + CWM_CSUM_W) begin
        s = s + {{(CWM_CSUM_W-1){1'b0}}, w[i]}; // see RULE7
      end
    end
    bit_sum = s;
  endfunction : bit_sum

  ////////////////////////////////////////////////////////////////////////////
  // state

  cwm_state_t state_r, state_nxt;
  logic [CWM_WORD_W-1:0] word_r, word_nxt;
  logic csum_err_r, csum_err_nxt;
  logic por_err_r, por_err_nxt;
  logic valid_r, valid_nxt;
  logic [CWM_DATA_W-1:0] rdata_r, rdata_nxt;
  cwm_trim_t trim_r, trim_nxt;
  logic [CWM_CLK_W-1:0] clk_trim_r, clk_trim_nxt;
  logic load_req;
  logic clr_req;
  logic [CWM_CSUM_W-1:0] csum_stored;
  logic [CWM_CAL_W-1:0] g100i;

  assign load_req = bus_i.wr && bus_i.addr == CWM_R_CTRL && bus_i.wdata[CWM_CT_LOAD];
  assign clr_req = bus_i.wr && bus_i.addr == CWM_R_CTRL && bus_i.wdata[CWM_CT_CLR];
  assign csum_stored = word_r[CWM_CSUM_LSB +: CWM_CSUM_W]; // see RULE6
  assign g100i = cal_at(word_r, CWM_G100I_LSB); // see RULE2

  ////////////////////////////////////////////////////////////////////////////
  // load and check sequence

  always_comb begin
    state_nxt = state_r;
    word_nxt = word_r;
    csum_err_nxt = csum_err_r;
    por_err_nxt = por_err_r;
    valid_nxt = valid_r;
    trim_nxt = trim_r;
    clk_trim_nxt = clk_trim_r;
    if (clr_req) begin
      csum_err_nxt = 1'b0;
      por_err_nxt = 1'b0;
    end
    case (state_r)
      CWM_IDLE: begin
        state_nxt = CWM_CHECK;
        word_nxt = stored_word_i;
        valid_nxt = 1'b0;
      end
      CWM_CHECK: begin
        // set wins over a clear in the same cycle
        if (bit_sum(word_r) != csum_stored) begin
          csum_err_nxt = 1'b1; // see RULE14
        end
        if (g100i != '0) begin
          por_err_nxt = 1'b1; // see RULE14
        end
        trim_nxt.current_source = word_r[CWM_CURRENT_SOURCE_TRIM_LSB +: CWM_TRIM_W];
        trim_nxt.amp_offset = word_r[CWM_AMP_OFFSET_TRIM_LSB +: CWM_TRIM_W];
        trim_nxt.ref_voltage = word_r[CWM_REFERENCE_VOLTAGE_TRIM_LSB +: CWM_TRIM_W];
        trim_nxt.ref_tempco = word_r[CWM_REFERENCE_TEMPCO_TRIM_LSB +: CWM_TRIM_W];
        clk_trim_nxt = word_r[CWM_CLK_LSB +: CWM_CLK_W]; // see RULE8
        valid_nxt = 1'b1;
        state_nxt = CWM_DONE;
      end
      CWM_DONE: begin
        if (load_req) begin
          state_nxt = CWM_IDLE;
        end
      end
      default: begin
        state_nxt = CWM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= CWM_IDLE;
      word_r <= '0;
      csum_err_r <= 1'b0;
      por_err_r <= 1'b0;
      valid_r <= 1'b0;
      trim_r <= '0;
      clk_trim_r <= '0;
    end else begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      csum_err_r <= csum_err_nxt;
      por_err_r <= por_err_nxt;
      valid_r <= valid_nxt;
      trim_r <= trim_nxt;
      clk_trim_r <= clk_trim_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  always_comb begin
    rdata_nxt = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        CWM_R_TOP: rdata_nxt = {11'h000, word_r[CWM_TOP_LSB +: CWM_TRIM_W]};
        CWM_R_CURRENT_SOURCE_TRIM: rdata_nxt = {11'h000, word_r[CWM_CURRENT_SOURCE_TRIM_LSB +: CWM_TRIM_W]};
        CWM_R_AMP_OFFSET_TRIM: rdata_nxt = {11'h000, word_r[CWM_AMP_OFFSET_TRIM_LSB +: CWM_TRIM_W]};
        CWM_R_REFERENCE_VOLTAGE_TRIM: rdata_nxt = {11'h000, word_r[CWM_REFERENCE_VOLTAGE_TRIM_LSB +: CWM_TRIM_W]};
        CWM_R_REFERENCE_TEMPCO_TRIM: rdata_nxt = {11'h000, word_r[CWM_REFERENCE_TEMPCO_TRIM_LSB +: CWM_TRIM_W]};
        CWM_R_G6I: rdata_nxt = pad(cal_at(word_r, CWM_G6I_LSB)); // see RULE1
        CWM_R_G24I: rdata_nxt = pad(cal_at(word_r, CWM_G24I_LSB)); // see RULE1
        CWM_R_G50I: rdata_nxt = pad(cal_at(word_r, CWM_G50I_LSB)); // see RULE1
        CWM_R_G100I: rdata_nxt = pad(g100i); // see RULE1
        CWM_R_G24F: rdata_nxt = pad(cal_at(word_r, CWM_G24F_LSB)); // see RULE3
        CWM_R_SPA: rdata_nxt = pad(cal_at(word_r, CWM_SPA_LSB));
        CWM_R_SPB: rdata_nxt = pad(cal_at(word_r, CWM_SPB_LSB));
        CWM_R_G1F: rdata_nxt = pad(cal_at(word_r, CWM_G1F_LSB)); // see RULE4
        CWM_R_G100F: rdata_nxt = pad(cal_at(word_r, CWM_G100F_LSB)); // see RULE4
        CWM_R_TEMPF: rdata_nxt = pad(cal_at(word_r, CWM_TEMPF_LSB)); // see RULE5
        CWM_R_CSUM: rdata_nxt = {7'h00, word_r[CWM_CSUM_LSB +: CWM_CSUM_FLD_W]}; // see RULE6
        // upper three bits of the clock field always read as ones
        CWM_R_CLK: rdata_nxt = {7'h00, CWM_CLK_ONES, word_r[CWM_CLK_LSB +: CWM_CLK_W]}; // see RULE8
        CWM_R_T23: rdata_nxt = pad(cal_at(word_r, CWM_T23_LSB)); // see RULE10
        CWM_R_SNH: rdata_nxt = {8'h00, word_r[CWM_SNH_LSB +: CWM_BYTE_W]}; // see RULE11
        CWM_R_SNM: rdata_nxt = {8'h00, word_r[CWM_SNM_LSB +: CWM_BYTE_W]}; // see RULE11
        CWM_R_SNL: rdata_nxt = {8'h00, word_r[CWM_SNL_LSB +: CWM_BYTE_W]}; // see RULE11
        CWM_R_STATUS: begin
          rdata_nxt[CWM_ST_CSUM] = csum_err_r;
          rdata_nxt[CWM_ST_POR] = por_err_r;
          rdata_nxt[CWM_ST_VALID] = valid_r;
        end
        CWM_R_OSC: rdata_nxt = CWM_OSC_BASE_KHZ + {10'h000, clk_trim_r}; // see RULE9
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign trim_group_o = trim_r;
  assign clock_trim_number_o = clk_trim_r;
  assign csum_err_o = csum_err_r;
  assign por_err_o = por_err_r;
  assign word_valid_o = valid_r;

endmodule : cwm_calibration_word_map

`default_nettype wire

// ==== core/cwm_pkg.sv ====
// package for the calibration word map: field positions, register indices, types
// assumes a single 50 MHz clock domain and a plain register port
package cwm_pkg;

  localparam int unsigned CWM_WORD_W = 188;
  localparam int unsigned CWM_CAL_W = 11;
  localparam int unsigned CWM_TRIM_W = 5;
  localparam int unsigned CWM_BYTE_W = 8;
  localparam int unsigned CWM_ADDR_W = 5;
  localparam int unsigned CWM_DATA_W = 16;

  // field low bit positions in the stored word
  localparam int unsigned CWM_TOP_LSB = 183;
  localparam int unsigned CWM_CURRENT_SOURCE_TRIM_LSB = 178;
  localparam int unsigned CWM_AMP_OFFSET_TRIM_LSB = 173;
  localparam int unsigned CWM_REFERENCE_VOLTAGE_TRIM_LSB = 168;
  localparam int unsigned CWM_REFERENCE_TEMPCO_TRIM_LSB = 163;
  localparam int unsigned CWM_G6I_LSB = 152;
  localparam int unsigned CWM_G24I_LSB = 141;
  localparam int unsigned CWM_G50I_LSB = 130;
  localparam int unsigned CWM_G100I_LSB = 119;
  localparam int unsigned CWM_G24F_LSB = 108;
  localparam int unsigned CWM_SPA_LSB = 97;
  localparam int unsigned CWM_SPB_LSB = 86;
  localparam int unsigned CWM_G1F_LSB = 75;
  localparam int unsigned CWM_G100F_LSB = 64;
  localparam int unsigned CWM_TEMPF_LSB = 53;
  localparam int unsigned CWM_CSUM_LSB = 44;
  localparam int unsigned CWM_CSUM_FLD_W = 9;
  localparam int unsigned CWM_CSUM_W = 8;
  localparam int unsigned CWM_CLK_LSB = 35;
  localparam int unsigned CWM_CLK_FLD_W = 9;
  localparam int unsigned CWM_CLK_W = 6;
  localparam int unsigned CWM_T23_LSB = 24;
  localparam int unsigned CWM_SNH_LSB = 16;
  localparam int unsigned CWM_SNM_LSB = 8;
  localparam int unsigned CWM_SNL_LSB = 0;

  // oscillator base frequency in kHz
  localparam logic [CWM_DATA_W-1:0] CWM_OSC_BASE_KHZ = 16'h00F0;
  localparam logic [2:0] CWM_CLK_ONES = 3'h7;

  // register indices on the read port
  localparam logic [CWM_ADDR_W-1:0] CWM_R_TOP = 5'h00;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_CURRENT_SOURCE_TRIM = 5'h01;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_AMP_OFFSET_TRIM = 5'h02;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_REFERENCE_VOLTAGE_TRIM = 5'h03;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_REFERENCE_TEMPCO_TRIM = 5'h04;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_G6I = 5'h05;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_G24I = 5'h06;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_G50I = 5'h07;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_G100I = 5'h08;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_G24F = 5'h09;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_SPA = 5'h0A;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_SPB = 5'h0B;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_G1F = 5'h0C;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_G100F = 5'h0D;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_TEMPF = 5'h0E;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_CSUM = 5'h0F;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_CLK = 5'h10;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_T23 = 5'h11;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_SNH = 5'h12;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_SNM = 5'h13;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_SNL = 5'h14;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_STATUS = 5'h15;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_CTRL = 5'h16;
  localparam logic [CWM_ADDR_W-1:0] CWM_R_OSC = 5'h17;

  // status bits
  localparam int unsigned CWM_ST_CSUM = 0;
  localparam int unsigned CWM_ST_POR = 1;
  localparam int unsigned CWM_ST_VALID = 2;
  // control bits
  localparam int unsigned CWM_CT_LOAD = 0;
  localparam int unsigned CWM_CT_CLR = 1;

  typedef struct packed {
    logic [CWM_ADDR_W-1:0] addr;
    logic [CWM_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cwm_bus_req_t;

  typedef struct packed {
    logic [CWM_TRIM_W-1:0] current_source;
    logic [CWM_TRIM_W-1:0] amp_offset;
    logic [CWM_TRIM_W-1:0] ref_voltage;
    logic [CWM_TRIM_W-1:0] ref_tempco;
  } cwm_trim_t;

  typedef enum logic [2:0] {
    CWM_IDLE = 3'b001,
    CWM_CHECK = 3'b010,
    CWM_DONE = 3'b100
  } cwm_state_t;

endpackage : cwm_pkg

// ==== verification/cwm_calibration_word_map_props.sv ====
// checker for the calibration word map ports
// assumes binding onto cwm_calibration_word_map, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cwm_calibration_word_map_props
  import cwm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // design inputs
  input wire logic [CWM_WORD_W-1:0] stored_word_i,
  input wire cwm_bus_req_t bus_i,
  // design outputs
  input wire logic [CWM_DATA_W-1:0] rdata_o,
  input wire cwm_trim_t trim_group_o,
  input wire logic [CWM_CLK_W-1:0] clock_trim_number_o,
  input wire logic csum_err_o,
  input wire logic por_err_o,
  input wire logic word_valid_o
);
  logic [7:0] sum_w;
  logic bad_sum_w;
  always_comb begin
    sum_w = 8'h00;
    for (int i = 0; i < 188; i++)
      if (i < 44 || i > 51)
        sum_w = sum_w + 8'(stored_word_i[i]);
    bad_sum_w = sum_w != stored_word_i[51:44];
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_load;
    bus_i.wr && bus_i.addr == CWM_R_CTRL && bus_i.wdata[CWM_CT_LOAD] && word_valid_o;
  endsequence
  sequence s_wake;
    !word_valid_o [*2] ##1 word_valid_o;
  endsequence
  a_reset_valid: assert property ($rose(rst_n_i) |-> s_wake) else $error("valid late after reset");
  // valid stays up through the idle cycle, drops for the check cycle, then returns
  a_reload_valid: assert property (s_load |=> word_valid_o ##1 !word_valid_o ##1 word_valid_o)
    else $error("reload walk");
  a_por_flag: assert property ($rose(word_valid_o) && $past(stored_word_i[129:119], 2) != 11'h000 |-> por_err_o)
    else $error("por flag missing");
  a_csum_flag: assert property ($rose(word_valid_o) && $past(bad_sum_w, 2) |-> csum_err_o)
    else $error("checksum flag missing");
  a_clk_trim: assert property ($rose(word_valid_o) |-> clock_trim_number_o == $past(stored_word_i[40:35], 2))
    else $error("clock trim wrong");
  a_trim_out: assert property ($rose(word_valid_o) |-> trim_group_o == $past(stored_word_i[182:163], 2))
    else $error("trim group wrong");
  a_osc_read: assert property (bus_i.rd && bus_i.addr == CWM_R_OSC && word_valid_o
    |=> rdata_o == 16'h00F0 + {10'h000, clock_trim_number_o}) else $error("osc read wrong");
  a_rdata_zero: assert property (!bus_i.rd |=> rdata_o == 16'h0000) else $error("rdata not zero");
  a_clear_flags: assert property (bus_i.wr && bus_i.addr == CWM_R_CTRL && bus_i.wdata[1:0] == 2'h2 && word_valid_o
    |=> !csum_err_o && !por_err_o) else $error("flags not cleared");
  a_wr_ignored: assert property (bus_i.wr && bus_i.addr != CWM_R_CTRL && word_valid_o
    |=> word_valid_o && $stable(csum_err_o) && $stable(por_err_o)) else $error("stray write acted");
endmodule : cwm_calibration_word_map_props
`default_nettype wire

// ==== verification/cwm_calibration_word_map_test.sv ====
// self-checking bench for the calibration word map
// assumes the reset walk and register map of the design
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp=%0h got=%0h", n, e, g); end end
module cwm_calibration_word_map_test
  import cwm_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [CWM_WORD_W-1:0] word_r = '0;
  cwm_bus_req_t bus_r = '0;
  logic [15:0] rdata_w;
  cwm_trim_t trim_w;
  logic [5:0] ctrim_w;
  logic csum_w, por_w, valid_w;
  logic [15:0] lfsr_r = 16'h27B0;
  logic [2:0] flags_r;
  int errors = 0;
  int check_count = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  cwm_calibration_word_map dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .stored_word_i(word_r), .bus_i(bus_r),
    .rdata_o(rdata_w), .trim_group_o(trim_w), .clock_trim_number_o(ctrim_w), .csum_err_o(csum_w),
    .por_err_o(por_w), .word_valid_o(valid_w));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  function automatic logic [7:0] sum_of(input logic [CWM_WORD_W-1:0] w);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 188; i++)
      if (i < 44 || i > 51)
        s = s + 8'(w[i]);
    return s;
  endfunction : sum_of
  function automatic logic [15:0] exp_reg(input logic [4:0] a, input logic [CWM_WORD_W-1:0] w, input logic [2:0] f);
    int lsb[21] = '{183, 178, 173, 168, 163, 152, 141, 130, 119, 108, 97, 86, 75, 64, 53, 44, 35, 24, 16, 8, 0};
    int wd;
    logic [15:0] r;
    wd = (a < 5) ? 5 : (a == 15 || a == 16) ? 9 : (a > 17) ? 8 : 11;
    r = 16'h0000;
    if (a < 5'h15)
      r = 16'((w >> lsb[a]) & ((188'h1 << wd) - 188'h1));
    else if (a == 5'h15)
      r = {13'h0, f};
    else if (a == 5'h17)
      r = 16'h00F0 + {10'h0, w[40:35]};
    if (a == 5'h10)
      r = r | 16'h01C0;
    return r;
  endfunction : exp_reg
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    bus_r.rd <= 1'b1;
    bus_r.addr <= a;
    @(posedge ref_clk_i);
    bus_r.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_w)
  endtask : rd_chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    bus_r.wr <= 1'b1;
    bus_r.addr <= a;
    bus_r.wdata <= d;
    @(posedge ref_clk_i);
    bus_r.wr <= 1'b0;
  endtask : wr
  task automatic check_all();
    for (int a = 0; a < 32; a++)
      rd_chk(5'(a), exp_reg(5'(a), word_r, flags_r));
    `CHK("trims", word_r[182:163], trim_w)
    `CHK("clock trim", word_r[40:35], ctrim_w)
    `CHK("status", flags_r, {valid_w, por_w, csum_w})
    $display("test done, checks %0d", check_count);
  endtask : check_all
  // random word, optionally with a bad checksum or a nonzero gain-100 word
  task automatic load_word(input bit bad, input bit por);
    logic [CWM_WORD_W-1:0] w;
    for (int i = 0; i < 12; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      w = {w[171:0], lfsr_r};
    end
    w[129:119] = por ? 11'(lfsr_r | 16'h0001) : 11'h000;
    w[51:44] = sum_of(w) ^ {7'h00, bad};
    flags_r = {1'b1, flags_r[1] | por, flags_r[0] | bad};
    @(posedge ref_clk_i);
    word_r <= w;
    wr(CWM_R_CTRL, 16'h0001);
    repeat (6) @(posedge ref_clk_i);
    check_all();
  endtask : load_word
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    flags_r = 3'b100;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    check_all();
    for (int k = 0; k < 6; k++)
      load_word(k[0], k == 3);
    wr(CWM_R_CURRENT_SOURCE_TRIM, 16'hFFFF);
    check_all();
    wr(CWM_R_CTRL, 16'h0002);
    flags_r = 3'b100;
    repeat (2) @(posedge ref_clk_i);
    check_all();
    // reset in mid-run re-latches and re-checks the word on the input
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    flags_r = {1'b1, word_r[129:119] != 11'h000, sum_of(word_r) != word_r[51:44]};
    repeat (4) @(posedge ref_clk_i);
    check_all();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    report_and_stop();
  end
endmodule : cwm_calibration_word_map_test
bind cwm_calibration_word_map cwm_calibration_word_map_props u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .stored_word_i(stored_word_i), .bus_i(bus_i), .rdata_o(rdata_o), .trim_group_o(trim_group_o),
  .clock_trim_number_o(clock_trim_number_o), .csum_err_o(csum_err_o), .por_err_o(por_err_o),
  .word_valid_o(word_valid_o));
`default_nettype wire
